//--- design/cwd_config_word_decoder.v
// configuration word store and decoder with an apb register port
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "cwd_defines.vh"

// Overview of operation
// - Unused bits of both words always read back as one.
// - Clock-output enable bit one gives general I/O, zero gives clock out.
// - Brown-out field: 11 on, 10 on while awake, 01 software, 00 off.
// - Code protection is active when bit 7 of word one is zero.
// - Once code protection is on only a bulk erase clears it; srst_i holds code_protect_o low only while asserted.
// - Reset-pin select is ignored under low-voltage programming.
// - Power-up timer enable bit is active low.
// - Brown-out and power-up timer settings decode independently.
// - Watchdog field: 11 on, 10 on while awake, 01 software, 00 off.
// - Oscillator field picks external high, medium, low or internal.
// - Low-voltage programming bit one allows low-voltage entry.
// - Low-power brown-out enable bit is active low.
// - Threshold bit one picks the low trip point, zero the high one.
module cwd_config_word_decoder (
  input wire clk_i,
  input wire srst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire pready_o,
  output reg [31:0] prdata_o,
  output wire pslverr_o,
  input wire sleep_i,
  input wire software_brownout_enable_i,
  input wire software_watchdog_enable_i,
  input wire port_pullup_ctrl_bit_i,
  input wire stack_fault_i,
  input wire [10:0] self_write_addr_i,
  output reg clock_output_pin_en_o,
  output reg brownout_reset_en_o,
  output reg code_protect_o,
  output reg external_reset_pin_en_o,
  output reg reset_pin_pullup_o,
  output reg powerup_delay_timer_en_o,
  output reg watchdog_en_o,
  output reg [1:0] oscillator_select_o,
  output reg clock_input_pin_used_o,
  output reg low_voltage_prog_enable_o,
  output reg low_power_brownout_en_o,
  output reg brownout_threshold_low_o,
  output reg stack_fault_reset_o,
  output reg self_write_blocked_o
);

  reg [13:0] word_one_r;
  reg [13:0] word_two_r;
  reg [13:0] word_one_nxt;
  reg [13:0] word_two_nxt;
  reg protect_lock_r;
  reg protect_lock_nxt;
  reg [31:0] rdata_nxt;
  reg bad_addr;
  reg clock_output_pin_en_nxt;
  reg brownout_reset_en_nxt;
  reg code_protect_nxt;
  reg external_reset_pin_en_nxt;
  reg reset_pin_pullup_nxt;
  reg powerup_delay_timer_en_nxt;
  reg watchdog_en_nxt;
  reg [1:0] oscillator_select_nxt;
  reg clock_input_pin_used_nxt;
  reg low_voltage_prog_enable_nxt;
  reg low_power_brownout_en_nxt;
  reg brownout_threshold_low_nxt;
  reg stack_fault_reset_nxt;
  reg self_write_blocked_nxt;

  wire wr_acc;
  wire rd_acc;
  wire erase_hit;
  wire [13:0] one_rd;
  wire [13:0] two_rd;

  // mode fields share one decode: on, on while awake, software, off
  function mode_en;
    input [1:0] mode;
    input asleep;
    input sw_en;
    begin
      case (mode)
        `CWD_MODE_ON: mode_en = 1'b1;
        `CWD_MODE_RUN: mode_en = ~asleep;
        `CWD_MODE_SW: mode_en = sw_en;
        default: mode_en = 1'b0;
      endcase
    end
  endfunction

  // merge a written word under the byte strobes
  function [13:0] strb_merge;
    input [13:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      strb_merge = old;
      if (strb[0]) begin
        strb_merge[7:0] = data[7:0];
      end
      if (strb[1]) begin
        strb_merge[13:8] = data[13:8];
      end
    end
  endfunction

  // every protected range starts at address zero, so only the ceiling
  // differs between codes; the widened address keeps the compare unsigned
  function self_wr_hit;
    input [1:0] range_sel;
    input [10:0] addr;
    begin
      case (range_sel)
        2'h2: self_wr_hit = ({1'b0, addr} <= `CWD_SELF_WR_LIM_10);
        2'h1: self_wr_hit = ({1'b0, addr} <= `CWD_SELF_WR_LIM_01);
        2'h0: self_wr_hit = ({1'b0, addr} <= `CWD_SELF_WR_LIM_00);
        default: self_wr_hit = 1'b0;
      endcase
    end
  endfunction

  // zero-wait slave: every access ends in its first access cycle
  assign pready_o = 1'b1;
  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign rd_acc = psel_i & penable_i & ~pwrite_i;
  assign pslverr_o = psel_i & penable_i & bad_addr;
  // erase needs the exact key on all lanes so a stray write cannot wipe
  assign erase_hit = wr_acc && (paddr_i == `CWD_OFS_ERASE) &&
    (pwdata_i == `CWD_ERASE_KEY) && (pstrb_i == 4'hF);

  assign one_rd = word_one_r | `CWD_ONE_FIXED_MASK;
  assign two_rd = word_two_r | `CWD_TWO_FIXED_MASK;

  always @* begin
    bad_addr = 1'b0;
    rdata_nxt = 32'h00000000;
    case (paddr_i)
      `CWD_OFS_WORD_ONE: rdata_nxt = {18'h00000, one_rd};
      `CWD_OFS_WORD_TWO: rdata_nxt = {18'h00000, two_rd};
      `CWD_OFS_CONTROL: rdata_nxt = {31'h00000000, protect_lock_r};
      `CWD_OFS_STATUS: rdata_nxt = {20'h00000, watchdog_en_o,
        brownout_reset_en_o, powerup_delay_timer_en_o,
        external_reset_pin_en_o, code_protect_o, clock_output_pin_en_o,
        low_power_brownout_en_o, low_voltage_prog_enable_o,
        brownout_threshold_low_o, stack_fault_reset_o,
        oscillator_select_o};
      `CWD_OFS_ERASE: rdata_nxt = 32'h00000000;
      default: bad_addr = 1'b1;
    endcase
  end

  always @* begin
    word_one_nxt = word_one_r;
    word_two_nxt = word_two_r;
    protect_lock_nxt = protect_lock_r;
    if (wr_acc) begin
      case (paddr_i)
        `CWD_OFS_WORD_ONE: begin
          word_one_nxt = strb_merge(word_one_r, pwdata_i, pstrb_i);
          if (protect_lock_r) begin
            word_one_nxt[`CWD_BIT_PROTECT_N] = 1'b0;
          end
        end
        `CWD_OFS_WORD_TWO: begin
          word_two_nxt = strb_merge(word_two_r, pwdata_i, pstrb_i);
        end
        `CWD_OFS_ERASE: begin
          if (erase_hit) begin
            word_one_nxt = `CWD_BLANK_WORD;
            word_two_nxt = `CWD_BLANK_WORD;
            protect_lock_nxt = 1'b0;
          end
        end
        default: begin
          word_one_nxt = word_one_r;
        end
      endcase
    end
    if (!word_one_nxt[`CWD_BIT_PROTECT_N]) begin
      protect_lock_nxt = 1'b1;
    end
  end

  // words model nonvolatile storage, so reset leaves them untouched;
  // they power up unknown until a bulk erase or a write under both low byte strobes gives them a defined value
  always @(posedge clk_i) begin
    word_one_r <= word_one_nxt;
    word_two_r <= word_two_nxt;
    if (srst_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_acc) begin
      prdata_o <= rdata_nxt;
    end
  end

  // the lock is nonvolatile like the words it guards
  always @(posedge clk_i) begin
    protect_lock_r <= protect_lock_nxt;
  end

  // decoded controls depend only on the stored words, the protection lock and live inputs
  always @* begin
    clock_output_pin_en_nxt = ~one_rd[`CWD_BIT_CLK_OUT_EN_N];
    brownout_reset_en_nxt = mode_en(
      one_rd[`CWD_BROWNOUT_HI:`CWD_BROWNOUT_LO], sleep_i,
      software_brownout_enable_i);
    code_protect_nxt = ~one_rd[`CWD_BIT_PROTECT_N] | protect_lock_r;
    if (two_rd[`CWD_BIT_LV_PROG] || one_rd[`CWD_BIT_RSTSEL]) begin
      external_reset_pin_en_nxt = 1'b1;
      reset_pin_pullup_nxt = 1'b1;
    end else begin
      external_reset_pin_en_nxt = 1'b0;
      reset_pin_pullup_nxt = port_pullup_ctrl_bit_i;
    end
    powerup_delay_timer_en_nxt = ~one_rd[`CWD_BIT_PWRUP_N];
    watchdog_en_nxt = mode_en(
      one_rd[`CWD_WDOG_HI:`CWD_WDOG_LO], sleep_i,
      software_watchdog_enable_i);
    oscillator_select_nxt = one_rd[`CWD_OSC_HI:`CWD_OSC_LO];
    clock_input_pin_used_nxt = |one_rd[`CWD_OSC_HI:`CWD_OSC_LO];
    low_voltage_prog_enable_nxt = two_rd[`CWD_BIT_LV_PROG];
    low_power_brownout_en_nxt = ~two_rd[`CWD_BIT_LP_BROWNOUT_N];
    brownout_threshold_low_nxt = two_rd[`CWD_BIT_TRIP_SEL];
    stack_fault_reset_nxt = stack_fault_i & two_rd[`CWD_BIT_STACK_RST];
    self_write_blocked_nxt = self_wr_hit(
      two_rd[`CWD_SELF_WR_HI:`CWD_SELF_WR_LO], self_write_addr_i);
  end

  // reset shows what blank words decode to, but with brown-out reset, watchdog and stack-fault reset held off,
  // so the core sees a safe setting while the stored words may still be unknown
  always @(posedge clk_i) begin
    if (srst_i) begin
      clock_output_pin_en_o <= 1'b0;
      brownout_reset_en_o <= 1'b0;
      code_protect_o <= 1'b0;
      external_reset_pin_en_o <= 1'b1;
      reset_pin_pullup_o <= 1'b1;
      powerup_delay_timer_en_o <= 1'b0;
      watchdog_en_o <= 1'b0;
      oscillator_select_o <= 2'h3;
      clock_input_pin_used_o <= 1'b1;
      low_voltage_prog_enable_o <= 1'b1;
      low_power_brownout_en_o <= 1'b0;
      brownout_threshold_low_o <= 1'b1;
      stack_fault_reset_o <= 1'b0;
      self_write_blocked_o <= 1'b0;
    end else begin
      clock_output_pin_en_o <= clock_output_pin_en_nxt;
      brownout_reset_en_o <= brownout_reset_en_nxt;
      code_protect_o <= code_protect_nxt;
      external_reset_pin_en_o <= external_reset_pin_en_nxt;
      reset_pin_pullup_o <= reset_pin_pullup_nxt;
      powerup_delay_timer_en_o <= powerup_delay_timer_en_nxt;
      watchdog_en_o <= watchdog_en_nxt;
      oscillator_select_o <= oscillator_select_nxt;
      clock_input_pin_used_o <= clock_input_pin_used_nxt;
      low_voltage_prog_enable_o <= low_voltage_prog_enable_nxt;
      low_power_brownout_en_o <= low_power_brownout_en_nxt;
      brownout_threshold_low_o <= brownout_threshold_low_nxt;
      // a level, not a pulse: the core times its own reset from it
      stack_fault_reset_o <= stack_fault_reset_nxt;
      self_write_blocked_o <= self_write_blocked_nxt;
    end
  end

endmodule

//--- design/cwd_defines.vh
// register offsets, field positions, erase key and blank word for the config word decoder
`ifndef CWD_DEFINES_VH
`define CWD_DEFINES_VH
`define CWD_OFS_WORD_ONE 12'h000
`define CWD_OFS_WORD_TWO 12'h004
`define CWD_OFS_CONTROL 12'h008
`define CWD_OFS_STATUS 12'h00C
`define CWD_OFS_ERASE 12'h010
`define CWD_ERASE_KEY 32'h0000A5E5
`define CWD_BLANK_WORD 14'h3FFF
`define CWD_ONE_FIXED_MASK 14'h3104
`define CWD_TWO_FIXED_MASK 14'h11FC
`define CWD_BIT_CLK_OUT_EN_N 11
`define CWD_BROWNOUT_HI 10
`define CWD_BROWNOUT_LO 9
`define CWD_BIT_PROTECT_N 7
`define CWD_BIT_RSTSEL 6
`define CWD_BIT_PWRUP_N 5
`define CWD_WDOG_HI 4
`define CWD_WDOG_LO 3
`define CWD_OSC_HI 1
`define CWD_OSC_LO 0
`define CWD_BIT_LV_PROG 13
`define CWD_BIT_LP_BROWNOUT_N 11
`define CWD_BIT_TRIP_SEL 10
`define CWD_BIT_STACK_RST 9
`define CWD_SELF_WR_HI 1
`define CWD_SELF_WR_LO 0
`define CWD_MODE_ON 2'h3
`define CWD_MODE_RUN 2'h2
`define CWD_MODE_SW 2'h1
`define CWD_MODE_OFF 2'h0
`define CWD_SELF_WR_LIM_10 12'h1FF
`define CWD_SELF_WR_LIM_01 12'h3FF
`define CWD_SELF_WR_LIM_00 12'h7FF
`endif

//--- test/cwd_monitor.sv
// port checker for the config word decoder
`timescale 1ns/10ps
`include "cwd_defines.vh"
module cwd_monitor (
  input wire clk_i,
  input wire srst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pslverr_o,
  input wire sleep_i,
  input wire software_watchdog_enable_i,
  input wire port_pullup_ctrl_bit_i,
  input wire stack_fault_i,
  input wire code_protect_o,
  input wire external_reset_pin_en_o,
  input wire reset_pin_pullup_o,
  input wire watchdog_en_o,
  input wire [1:0] oscillator_select_o,
  input wire clock_input_pin_used_o,
  input wire low_voltage_prog_enable_o,
  input wire stack_fault_reset_o
);
  wire wr = psel_i && penable_i && pwrite_i;
  wire ers = wr && paddr_i == `CWD_OFS_ERASE && pwdata_i == `CWD_ERASE_KEY;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wdog_rise_a: assert property ($rose(watchdog_en_o) |->
    $past(wr) || $past(wr, 2) || $past(srst_i, 2) ||
    $past(sleep_i, 2) && !$past(sleep_i) ||
    $past(software_watchdog_enable_i) &&
    !$past(software_watchdog_enable_i, 2)) else $error("watchdog rose");
  protect_fall_a: assert property ($fell(code_protect_o) |->
    $past(ers) || $past(ers, 2)) else $error("protection dropped");
  stack_cause_a: assert property (stack_fault_reset_o |->
    $past(stack_fault_i)) else $error("stack reset without fault");
  stack_rise_a: assert property ($rose(stack_fault_reset_o) |->
    $past(wr, 2) || $past(srst_i, 2) || !$past(stack_fault_i, 2))
    else $error("stack reset rose late");
  osc_pin_a: assert property (clock_input_pin_used_o ==
    (oscillator_select_o != 2'h0)) else $error("clock pin use wrong");
  pin_pull_a: assert property (external_reset_pin_en_o |->
    reset_pin_pullup_o) else $error("reset pin lacks pull-up");
  pin_input_a: assert property (!low_voltage_prog_enable_o &&
    !external_reset_pin_en_o |->
    reset_pin_pullup_o == $past(port_pullup_ctrl_bit_i))
    else $error("pull-up ignores port control");
  bus_err_a: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access phase");
endmodule
bind cwd_config_word_decoder cwd_monitor cwd_monitor_inst (.*);

//--- test/cwd_programmer.sv
// apb programmer model that loads the configuration store
`timescale 1ns/10ps
module cwd_programmer (
  input wire clk_i,
  input wire pready_i,
  input wire pslverr_i,
  output reg psel_o = 1'b0,
  output reg penable_o = 1'b0,
  output reg pwrite_o = 1'b0,
  output reg [11:0] paddr_o = 12'h000,
  output reg [31:0] pwdata_o = 32'h0,
  output reg [3:0] pstrb_o = 4'hF
);
  task xfer(input bit w, input [11:0] a, input [31:0] d, output e);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

//--- test/tb_top.sv
// self-checking bench for the config word decoder
`timescale 1ns/10ps
`include "cwd_defines.vh"
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin n_mismatch++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, x); end end
module tb_top;
  reg clk_i = 1'b0, srst_i = 1'b1, sleep_i = 1'b0, stack_fault_i = 1'b0;
  reg software_brownout_enable_i = 1'b0, software_watchdog_enable_i = 1'b0;
  reg port_pullup_ctrl_bit_i = 1'b0, x, e;
  reg [10:0] self_write_addr_i = 11'h000;
  wire psel_i, penable_i, pwrite_i, pready_o, pslverr_o, clock_output_pin_en_o;
  wire brownout_reset_en_o, code_protect_o, external_reset_pin_en_o;
  wire reset_pin_pullup_o, powerup_delay_timer_en_o, watchdog_en_o;
  wire clock_input_pin_used_o, low_voltage_prog_enable_o, stack_fault_reset_o;
  wire low_power_brownout_en_o, brownout_threshold_low_o, self_write_blocked_o;
  wire [11:0] paddr_i;
  wire [31:0] pwdata_i, prdata_o;
  wire [3:0] pstrb_i;
  wire [1:0] oscillator_select_o;
  int n_mismatch = 0, n_tests = 0, i;
  always #5 clk_i = ~clk_i;
  cwd_config_word_decoder cwd_config_word_decoder_inst (.*);
  cwd_programmer cwd_programmer_inst (.clk_i(clk_i), .pready_i(pready_o),
    .pslverr_i(pslverr_o), .psel_o(psel_i), .penable_o(penable_i),
    .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i),
    .pstrb_o(pstrb_i));
  task wr(input [11:0] a, input [31:0] d);
    cwd_programmer_inst.xfer(1'b1, a, d, e);
  endtask
  task rd(input [11:0] a, input [31:0] d);
    cwd_programmer_inst.xfer(1'b0, a, 32'h0, e);
    @(negedge clk_i);
    `CHK(prdata_o, d)
  endtask
  task st;
    repeat (3) @(negedge clk_i);
  endtask
  task end_sim;
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    // blank the store while reset holds, so no output decodes unknown words
    wr(`CWD_OFS_ERASE, `CWD_ERASE_KEY);
    repeat (17) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(`CWD_OFS_WORD_ONE, 32'h3FFF);
    wr(`CWD_OFS_WORD_ONE, 32'h0);
    rd(`CWD_OFS_WORD_ONE, 32'h3104);
    st;
    `CHK(clock_output_pin_en_o, 1'b1)
    `CHK(code_protect_o, 1'b1)
    `CHK(powerup_delay_timer_en_o, 1'b1)
    wr(`CWD_OFS_WORD_ONE, 32'h3FFF);
    rd(`CWD_OFS_WORD_ONE, 32'h3F7F);
    for (i = 0; i < 16; i++) begin
      wr(`CWD_OFS_WORD_ONE, {18'h0, 3'h7, i[3:2], 4'hF, i[3:2], 1'b1, i[1:0]});
      sleep_i <= i[0];
      software_watchdog_enable_i <= i[1];
      software_brownout_enable_i <= i[1];
      st;
      x = i[3:2] == 3 || i[3:2] == 2 && !i[0] || i[3:2] == 1 && i[1];
      `CHK(watchdog_en_o, x)
      `CHK(brownout_reset_en_o, x)
      `CHK(powerup_delay_timer_en_o, 1'b0)
      `CHK(oscillator_select_o, i[1:0])
      `CHK(clock_input_pin_used_o, i[1:0] != 0)
    end
    `CHK(code_protect_o, 1'b1)
    wr(`CWD_OFS_WORD_TWO, 32'h0);
    stack_fault_i <= 1'b1;
    rd(`CWD_OFS_WORD_TWO, 32'h11FC);
    st;
    `CHK(low_voltage_prog_enable_o, 1'b0)
    `CHK(low_power_brownout_en_o, 1'b1)
    `CHK(brownout_threshold_low_o, 1'b0)
    `CHK(stack_fault_reset_o, 1'b0)
    `CHK(external_reset_pin_en_o, 1'b1)
    wr(`CWD_OFS_WORD_ONE, 32'h3FBF);
    port_pullup_ctrl_bit_i <= 1'b1;
    st;
    `CHK(external_reset_pin_en_o, 1'b0)
    `CHK(reset_pin_pullup_o, 1'b1)
    port_pullup_ctrl_bit_i <= 1'b0;
    st;
    `CHK(reset_pin_pullup_o, 1'b0)
    for (i = 0; i < 8; i++) begin
      wr(`CWD_OFS_WORD_TWO, {18'h0, 12'hFFF, i[2:1]});
      self_write_addr_i <= (i[2:1] == 2 ? 11'h1FF : i[2:1] == 1 ? 11'h3FF :
        11'h7FF) + i[0];
      st;
      x = i[2:1] != 3 && (i[0] == 0 || i[2:1] == 0);
      `CHK(self_write_blocked_o, x)
    end
    `CHK(low_voltage_prog_enable_o, 1'b1)
    `CHK(low_power_brownout_en_o, 1'b0)
    `CHK(brownout_threshold_low_o, 1'b1)
    `CHK(stack_fault_reset_o, 1'b1)
    cwd_programmer_inst.xfer(1'b0, 12'h020, 32'h0, e);
    `CHK(e, 1'b1)
    wr(`CWD_OFS_ERASE, `CWD_ERASE_KEY);
    st;
    `CHK(code_protect_o, 1'b0)
    rd(`CWD_OFS_WORD_ONE, 32'h3FFF);
    end_sim;
  end
endmodule
